//--- inc/cic_pkg.sv
// Purpose: Constants and types for the core interrupt controller
// Assumes: 8-bit core, four-phase instruction cycle, AHB-Lite access
// Notes: Register offsets are byte addresses of aligned words
//
// What this block does
// RQ1 - Any reset leaves the global enable cleared, so nothing vectors.
// RQ2 - Redirect only with global and source enable, plus group enable for peripheral sources.
// RQ3 - A source flag sets on its event whatever the enables say.
// RQ4 - Taking an interrupt flushes the prefetched instruction, clears global enable.
// RQ5 - Entry pushes the program counter and copies core context to shadow.
// RQ6 - Entry ends by loading the program counter with the vector.
// RQ7 - Reset vector is address 0000h, interrupt vector is 0004h.
// RQ8 - With global enable clear events only flag; serviced once re-enabled.
// RQ9 - Return instruction pops the stack, restores context, sets global enable.
// RQ10 - Service code clears handled flags before returning, else re-entry.
// RQ11 - Service code finds the source by polling the flags.
// RQ12 - Synchronous sources reach the vector three or four instruction cycles later.
// RQ13 - Asynchronous sources reach the vector three to five cycles later.
// RQ14 - Flags live in control and three peripheral registers, enables alike.
// RQ15 - Pending is OR of flag AND enable, peripheral part group-gated, global-qualified.
package cic_pkg;
    localparam int AW = 8;
    localparam int PCW = 15;
    localparam int NPER = 3;
    localparam int STS_W = 3;
    localparam logic [1:0] PH_LAST = 2'h3;
    localparam logic [PCW-1:0] RESET_VEC = 15'h0000;
    localparam logic [PCW-1:0] IRQ_VEC = 15'h0004;
    // Register offsets
    localparam logic [AW-1:0] OFF_CTRL = 8'h00;
    localparam logic [NPER-1:0][AW-1:0] OFF_PF = {8'h0C, 8'h08, 8'h04};
    localparam logic [NPER-1:0][AW-1:0] OFF_PE = {8'h18, 8'h14, 8'h10};
    localparam logic [AW-1:0] OFF_STS = 8'h1C;
    localparam logic [AW-1:0] OFF_MSK = 8'h20;
    localparam logic [AW-1:0] OFF_STATE = 8'h24;
    // Control register fields
    localparam int GIE_B = 7;
    localparam int PERIPHERAL_GROUP_ENABLE_B = 6;
    localparam int CF_CHG = 0;
    localparam int CF_EXT = 1;
    localparam int CF_TMR = 2;
    localparam int CE_OFS = 3;
    localparam logic [2:0] CF_MASK = 3'h7;
    // Implemented bits of the peripheral registers
    localparam logic [NPER-1:0][7:0] PER_IMPL = {8'hFF, 8'hF9, 8'hFF};
    // Status bits
    localparam int ST_ENTRY = 0;
    localparam int ST_RETURN = 1;
    localparam int ST_DEFER = 2;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
    typedef enum logic [1:0] {
        ENT_IDLE,
        ENT_FLUSH,
        ENT_SAVE,
        ENT_VECT
    } cic_ent_t;
endpackage

//--- logic/cic_sync3.sv
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Input is asynchronous to mclk_i
// Notes: Output changes only when the last two stages agree
`timescale 1ns/1ps
module cic_sync3
    import cic_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic level_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } cic_sync_t;

    cic_sync_t st_ff;
    cic_sync_t nxt_st;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.s1 = async_i;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        if (st_ff.s2 == st_ff.s3)
        begin
            nxt_st.lvl = st_ff.s3;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Agreed level passes at once, saving one clock of pin latency
    assign level_o = (st_ff.s2 == st_ff.s3) ? st_ff.s3 : st_ff.lvl;
endmodule

//--- logic/cic_top.sv
// Purpose: Core interrupt controller with AHB-Lite register access
// Assumes: Core decodes the return instruction and owns the stack
// Notes: One instruction cycle is four clocks; entry takes three
`timescale 1ns/1ps
module cic_top
    import cic_pkg::*;
#(
    parameter int CTX_W = 16
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic tmr_evt_i,
    input wire logic chg_evt_i,
    input wire logic ext_pin_i,
    input wire logic [8*NPER-1:0] periph_evt_i,
    input wire logic [PCW-1:0] cur_pc_i,
    input wire logic [CTX_W-1:0] ctx_i,
    input wire logic ret_instr_i,
    output logic flush_o,
    output logic push_o,
    output logic [PCW-1:0] push_pc_o,
    output logic shadow_save_o,
    output logic [CTX_W-1:0] shadow_ctx_o,
    output logic shadow_restore_o,
    output logic pop_o,
    output logic pc_load_o,
    output logic [PCW-1:0] pc_vector_o,
    output logic irq_o
);
    typedef struct packed {
        logic hready;
        logic [31:0] hrdata;
        logic hresp;
        logic dp_act;
        logic dp_wr;
        logic [AW-1:0] dp_addr;
        logic [7:0] ctrl;
        logic [NPER-1:0][7:0] pf;
        logic [NPER-1:0][7:0] pe;
        logic [STS_W-1:0] sts;
        logic [STS_W-1:0] msk;
        logic irq;
        cic_ent_t ent;
        logic [1:0] phase;
        logic flush;
        logic push;
        logic save;
        logic [PCW-1:0] pc_push;
        logic [CTX_W-1:0] shadow;
        logic restore;
        logic pop;
        logic pc_load;
        logic [PCW-1:0] pc_vec;
        logic boot;
        logic ext_prev;
    } cic_st_t;

    cic_st_t st_ff;
    cic_st_t nxt_st;
    logic ext_lvl;
    logic core_pend;
    logic per_pend;
    logic pend;
    logic [8*NPER-1:0] evt_m;

    function automatic logic [7:0] reg_rd(input cic_st_t s,
                                          input logic [AW-1:0] a,
                                          input logic p);
        logic [7:0] r;
        r = 8'h00;
        if (a == OFF_CTRL)
        begin
            r = s.ctrl;
        end
        if (a == OFF_STS)
        begin
            r = {5'h00, s.sts};
        end
        if (a == OFF_MSK)
        begin
            r = {5'h00, s.msk};
        end
        if (a == OFF_STATE)
        begin
            r = {3'h0, p, s.phase, s.ent};
        end
        for (int i = 0; i < NPER; i++)
        begin
            if (a == OFF_PF[i])
            begin
                r = s.pf[i];
            end
            if (a == OFF_PE[i])
            begin
                r = s.pe[i];
            end
        end
        return r;
    endfunction

    // RQ13 external pin synchronised
    cic_sync3 u_ext_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .async_i(ext_pin_i),
        .level_o(ext_lvl)
    );

    // RQ15 pending request
    assign core_pend = |(st_ff.ctrl[CE_OFS +: 3] & st_ff.ctrl[2:0]);
    assign per_pend = |(st_ff.pf & st_ff.pe);
    assign pend = st_ff.ctrl[GIE_B]
                  & (core_pend | (st_ff.ctrl[PERIPHERAL_GROUP_ENABLE_B] & per_pend));
    assign evt_m = periph_evt_i & PER_IMPL;

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.flush = 1'b0;
        nxt_st.push = 1'b0;
        nxt_st.save = 1'b0;
        nxt_st.restore = 1'b0;
        nxt_st.pop = 1'b0;
        nxt_st.pc_load = 1'b0;
        nxt_st.boot = 1'b0;
        nxt_st.hresp = 1'b0;
        nxt_st.ext_prev = ext_lvl;
        // RQ12 entry steps on instruction cycles
        nxt_st.phase = 2'(st_ff.phase + 2'h1);
        // RQ7 reset vector load
        if (st_ff.boot)
        begin
            nxt_st.pc_load = 1'b1;
            nxt_st.pc_vec = RESET_VEC;
        end
        // Bus address phase, one wait state
        if (st_ff.hready && hsel_i && htrans_i[1] && hready_i)
        begin
            nxt_st.dp_act = 1'b1;
            nxt_st.dp_wr = hwrite_i;
            nxt_st.dp_addr = haddr_i[AW-1:0];
            nxt_st.hready = 1'b0;
        end
        if (st_ff.dp_act)
        begin
            nxt_st.dp_act = 1'b0;
            nxt_st.hready = 1'b1;
            if (!st_ff.dp_wr)
            begin
                nxt_st.hrdata = {24'h000000, reg_rd(st_ff, st_ff.dp_addr, pend)};
            end
            else
            begin
                nxt_st.hrdata = RD_ZERO;
                // RQ14 flag and enable layout
                if (st_ff.dp_addr == OFF_CTRL)
                begin
                    nxt_st.ctrl = hwdata_i[7:0];
                end
                for (int i = 0; i < NPER; i++)
                begin
                    if (st_ff.dp_addr == OFF_PF[i])
                    begin
                        nxt_st.pf[i] = hwdata_i[7:0] & PER_IMPL[i];
                    end
                    if (st_ff.dp_addr == OFF_PE[i])
                    begin
                        nxt_st.pe[i] = hwdata_i[7:0] & PER_IMPL[i];
                    end
                end
                if (st_ff.dp_addr == OFF_STS)
                begin
                    nxt_st.sts = st_ff.sts & ~hwdata_i[STS_W-1:0];
                end
                if (st_ff.dp_addr == OFF_MSK)
                begin
                    nxt_st.msk = hwdata_i[STS_W-1:0];
                end
            end
        end
        // RQ3 flags set regardless of enables, set wins
        nxt_st.ctrl[CF_TMR] = nxt_st.ctrl[CF_TMR] | tmr_evt_i;
        nxt_st.ctrl[CF_CHG] = nxt_st.ctrl[CF_CHG] | chg_evt_i;
        // RQ13 edge of the synchronised pin
        nxt_st.ctrl[CF_EXT] = nxt_st.ctrl[CF_EXT]
                              | (ext_lvl & ~st_ff.ext_prev);
        for (int i = 0; i < NPER; i++)
        begin
            nxt_st.pf[i] = nxt_st.pf[i] | evt_m[8*i +: 8];
        end
        // RQ8 event held while globally disabled
        if (!st_ff.ctrl[GIE_B] && (tmr_evt_i || chg_evt_i || (|evt_m)
            || (ext_lvl && !st_ff.ext_prev)))
        begin
            nxt_st.sts[ST_DEFER] = 1'b1;
        end
        case (st_ff.ent)
            ENT_IDLE:
            begin
                // RQ9 return restores and re-enables
                if (ret_instr_i)
                begin
                    nxt_st.pop = 1'b1;
                    nxt_st.restore = 1'b1;
                    nxt_st.ctrl[GIE_B] = 1'b1;
                    nxt_st.sts[ST_RETURN] = 1'b1;
                end
                // RQ2 take only a qualified request
                else if (pend && st_ff.phase == PH_LAST)
                begin
                    // RQ4 flush and clear global enable
                    nxt_st.ent = ENT_FLUSH;
                    nxt_st.flush = 1'b1;
                    nxt_st.ctrl[GIE_B] = 1'b0;
                    nxt_st.sts[ST_ENTRY] = 1'b1;
                end
            end
            ENT_FLUSH:
            begin
                // RQ5 push and shadow save
                if (st_ff.phase == PH_LAST)
                begin
                    nxt_st.ent = ENT_SAVE;
                    nxt_st.push = 1'b1;
                    nxt_st.save = 1'b1;
                    nxt_st.pc_push = cur_pc_i;
                    nxt_st.shadow = ctx_i;
                end
            end
            ENT_SAVE:
            begin
                if (st_ff.phase == PH_LAST)
                begin
                    nxt_st.ent = ENT_VECT;
                end
            end
            ENT_VECT:
            begin
                // RQ6 load the interrupt vector
                if (st_ff.phase == PH_LAST)
                begin
                    nxt_st.ent = ENT_IDLE;
                    nxt_st.pc_load = 1'b1;
                    nxt_st.pc_vec = IRQ_VEC;
                end
            end
            default:
            begin
                nxt_st.ent = ENT_IDLE;
            end
        endcase
        nxt_st.irq = |(nxt_st.sts & nxt_st.msk);
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            // RQ1 global enable cleared on reset
            st_ff <= '0;
            st_ff.ctrl <= RST_CTRL;
            st_ff.hready <= 1'b1;
            st_ff.ent <= ENT_IDLE;
            st_ff.boot <= 1'b1;
            st_ff.pc_vec <= RESET_VEC;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign hrdata_o = st_ff.hrdata;
    assign hreadyout_o = st_ff.hready;
    assign hresp_o = st_ff.hresp;
    assign flush_o = st_ff.flush;
    assign push_o = st_ff.push;
    assign push_pc_o = st_ff.pc_push;
    assign shadow_save_o = st_ff.save;
    assign shadow_ctx_o = st_ff.shadow;
    assign shadow_restore_o = st_ff.restore;
    assign pop_o = st_ff.pop;
    assign pc_load_o = st_ff.pc_load;
    assign pc_vector_o = st_ff.pc_vec;
    assign irq_o = st_ff.irq;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    a_reset_gie_off: assert property ( // RQ1
        $fell(rst_i) |-> !st_ff.ctrl[GIE_B] ##1 !flush_o)
        else $error("global enable set after reset");
    a_entry_gated: assert property ( // RQ2
        $rose(flush_o) |-> $past(pend))
        else $error("entry without qualified request");
    a_tmr_flag_set: assert property ( // RQ3
        tmr_evt_i |=> st_ff.ctrl[CF_TMR])
        else $error("timer flag not set");
    a_per_flag_set: assert property ( // RQ3
        (|evt_m) |=> ((st_ff.pf & $past(evt_m)) == $past(evt_m)))
        else $error("peripheral flag not set");
    a_flush_gie_clr: assert property ( // RQ4
        flush_o |-> !st_ff.ctrl[GIE_B] && st_ff.ent == ENT_FLUSH)
        else $error("global enable not cleared at flush");
    a_push_and_save: assert property ( // RQ5
        flush_o |-> ##4 (push_o && shadow_save_o))
        else $error("push or shadow save missing");
    a_vector_load: assert property ( // RQ6
        push_o |-> ##8 (pc_load_o && pc_vector_o == IRQ_VEC))
        else $error("interrupt vector not loaded");
    a_boot_vector: assert property ( // RQ7
        $fell(rst_i) |=> (pc_load_o && pc_vector_o == RESET_VEC))
        else $error("reset vector not loaded");
    a_no_entry_off: assert property ( // RQ8
        (!st_ff.ctrl[GIE_B] && st_ff.ent == ENT_IDLE) |=> !flush_o)
        else $error("entry while globally disabled");
    a_return_gie: assert property ( // RQ9
        (ret_instr_i && st_ff.ent == ENT_IDLE)
        |=> (pop_o && shadow_restore_o && st_ff.ctrl[GIE_B]))
        else $error("return did not restore");
    a_sync_latency: assert property ( // RQ12
        (tmr_evt_i && st_ff.ctrl[CE_OFS + CF_TMR] && st_ff.ctrl[GIE_B]
         && st_ff.ent == ENT_IDLE && !pend && !ret_instr_i
         && !st_ff.dp_act)
        |-> ##[14:17] pc_load_o)
        else $error("synchronous latency out of range");

    c_entry: cover property (push_o ##8 pc_load_o);
    c_return: cover property (ret_instr_i ##1 pop_o);
    c_deferred: cover property ($rose(st_ff.sts[ST_DEFER]));
    c_ext_flag: cover property ($rose(st_ff.ctrl[CF_EXT]));
endmodule

//--- verif/cic_core_model.sv
// Purpose: Core fetch and return stack model facing the controller
// Assumes: One instruction cycle is four clocks
// Notes: Fetch stalls from flush until the vector load
`timescale 1ns/1ps
module cic_core_model
    import cic_pkg::*;
#(
    parameter int CTX_W = 16
)
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic push_i,
    input wire logic [PCW-1:0] push_pc_i,
    input wire logic pop_i,
    input wire logic pc_load_i,
    input wire logic [PCW-1:0] pc_vector_i,
    input wire logic ret_req_i,
    output logic [PCW-1:0] pc_o,
    output logic [CTX_W-1:0] ctx_o,
    output logic ret_instr_o,
    output logic [PCW-1:0] loaded_o,
    output logic [PCW-1:0] frz_o,
    output logic [7:0] entries_o
);
    logic [PCW-1:0] stk [16];
    logic [3:0] depth;
    logic [1:0] tick;
    logic stall;

    // Context follows the fetch address
    assign ctx_o = CTX_W'({pc_o, 1'b1});

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            pc_o <= 15'h7FF0;
            loaded_o <= 15'h7FFF;
            frz_o <= 15'h0000;
            entries_o <= 8'h00;
            depth <= 4'h0;
            tick <= 2'h0;
            stall <= 1'b0;
            ret_instr_o <= 1'b0;
        end
        else
        begin
            ret_instr_o <= ret_req_i;
            tick <= tick + 2'h1;
            if (flush_i)
            begin
                stall <= 1'b1;
                frz_o <= pc_o;
                entries_o <= entries_o + 8'h01;
            end
            if (push_i)
            begin
                stk[depth] <= push_pc_i;
                depth <= depth + 4'h1;
            end
            if (pc_load_i)
            begin
                pc_o <= pc_vector_i;
                loaded_o <= pc_vector_i;
                stall <= 1'b0;
            end
            else if (pop_i)
            begin
                pc_o <= stk[depth-4'h1];
                loaded_o <= stk[depth-4'h1];
                depth <= depth - 4'h1;
            end
            else if (!stall && tick == 2'h3)
                pc_o <= pc_o + 15'h0001;
        end
    end
endmodule

//--- verif/core_interrupt_controller_tb.sv
// Purpose: Register and core-link tests of the interrupt controller
// Assumes: Single AHB-Lite slave, hready looped back
// Notes: Events are {peripheral, timer, pin, change}
`timescale 1ns/1ps
module core_interrupt_controller_tb
    import cic_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [26:0] evt = 27'h0;
    logic ret_req = 1'b0;
    logic [31:0] hrdata;
    logic hready, hresp, flush, push, sh_save, sh_rest, pop, pc_load, irq;
    logic ret_instr;
    logic [PCW-1:0] cur_pc, push_pc, pc_vec, loaded, frz;
    logic [15:0] ctx, sh_ctx;
    logic [7:0] entries;
    int errors = 0;
    int checks_done = 0;
    int s;
    logic [31:0] exp = 32'h0;

    always #10 mclk = ~mclk;

    cic_top DUT (.mclk_i(mclk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .tmr_evt_i(evt[2]),
        .chg_evt_i(evt[0]), .ext_pin_i(evt[1]), .periph_evt_i(evt[26:3]),
        .cur_pc_i(cur_pc), .ctx_i(ctx), .ret_instr_i(ret_instr),
        .flush_o(flush), .push_o(push), .push_pc_o(push_pc),
        .shadow_save_o(sh_save), .shadow_ctx_o(sh_ctx),
        .shadow_restore_o(sh_rest), .pop_o(pop), .pc_load_o(pc_load),
        .pc_vector_o(pc_vec), .irq_o(irq));

    cic_core_model core (.mclk_i(mclk), .rst_i(rst), .flush_i(flush),
        .push_i(push), .push_pc_i(push_pc), .pop_i(pop), .pc_load_i(pc_load),
        .pc_vector_i(pc_vec), .ret_req_i(ret_req), .pc_o(cur_pc), .ctx_o(ctx),
        .ret_instr_o(ret_instr), .loaded_o(loaded), .frz_o(frz),
        .entries_o(entries));

    task finish_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge mclk);
        while (hready !== 1'b1 && n < 50)
        begin
            @(posedge mclk);
            n++;
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge mclk);
        while (hready !== 1'b1 && n < 50)
        begin
            @(posedge mclk);
            n++;
        end
        r = hrdata;
        chk("bus wait", 1, n < 50);
        chk("bus resp", 0, hresp);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ahb(1'b1, a, d, r);
    endtask

    task rd(input string what, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(what, e, r);
    endtask

    task irq_chk(input logic e);
        repeat (2) @(posedge mclk);
        chk("irq", e, irq);
    endtask

    // Drive events, then watch for an entry over 60 edges
    task fire(input logic [26:0] e, input logic want, input int lo,
        input int hi);
        int n;
        int k;
        n = 0;
        @(posedge mclk);
        evt <= e;
        for (k = 1; k <= 60; k++)
        begin
            @(posedge mclk);
            if (k == 4)
                evt <= 27'h0;
            if (pc_load === 1'b1 && n == 0)
                n = k;
            if (push === 1'b1)
                chk("shadow save", 1, sh_save);
        end
        chk("entry", want, n != 0);
        if (want)
        begin
            chk("latency", 1, n >= lo && n <= hi);
            chk("vector", IRQ_VEC, loaded);
            chk("pushed pc", frz, push_pc);
            chk("shadow", {frz, 1'b1}, sh_ctx);
        end
    endtask

    // Clear the handled flag, then return from service
    task ret(input logic [7:0] a, input logic [31:0] d);
        int n;
        int k;
        n = 0;
        wr(a, d);
        @(posedge mclk);
        ret_req <= 1'b1;
        @(posedge mclk);
        ret_req <= 1'b0;
        for (k = 1; k <= 6; k++)
        begin
            @(posedge mclk);
            if (pop === 1'b1 && n == 0)
            begin
                n = k;
                chk("restore", 1, sh_rest);
            end
        end
        chk("pop", 1, n != 0);
        chk("return pc", frz, loaded);
    endtask

    initial
    begin
        repeat (5000) @(posedge mclk);
        errors++;
        finish_test;
    end

    initial
    begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("reset vector", RESET_VEC, loaded);
        rd("ctrl reset", OFF_CTRL, 32'h0);
        for (s = 0; s < 3; s++)
        begin
            fire(27'h1 << s, 1'b0, 0, 0);
            exp = exp | (32'h1 << s);
            rd("ctrl flag", OFF_CTRL, exp);
        end
        fire(27'h8, 1'b0, 0, 0);
        rd("pf1 flag", OFF_PF[0], 32'h1);
        wr(OFF_PE[1], 32'hFF);
        rd("pe2 bits", OFF_PE[1], 32'hF9);
        rd("unmapped", 8'h40, 32'h0);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_PF[0], 32'h0);
        rd("ctrl clear", OFF_CTRL, 32'h0);
        wr(OFF_CTRL, 32'h20);
        fire(27'h4, 1'b0, 0, 0);
        rd("status defer", OFF_STS, 32'h4);
        wr(OFF_STS, 32'h7);
        wr(OFF_CTRL, 32'hA4);
        fire(27'h0, 1'b1, 1, 40);
        rd("ctrl entry", OFF_CTRL, 32'h24);
        chk("flushes", 1, entries);
        rd("status", OFF_STS, 32'h1);
        wr(OFF_MSK, 32'h1);
        irq_chk(1'b1);
        wr(OFF_MSK, 32'h0);
        irq_chk(1'b0);
        wr(OFF_MSK, 32'h1);
        wr(OFF_STS, 32'h1);
        irq_chk(1'b0);
        ret(OFF_CTRL, 32'h20);
        rd("ctrl return", OFF_CTRL, 32'hA0);
        fire(27'h0, 1'b0, 0, 0);
        fire(27'h4, 1'b1, 14, 19);
        ret(OFF_CTRL, 32'h20);
        wr(OFF_CTRL, 32'h90);
        fire(27'h2, 1'b1, 17, 21);
        ret(OFF_CTRL, 32'h10);
        wr(OFF_PE[0], 32'h1);
        wr(OFF_CTRL, 32'h80);
        fire(27'h8, 1'b0, 0, 0);
        wr(OFF_CTRL, 32'hC0);
        fire(27'h0, 1'b1, 1, 40);
        ret(OFF_PF[0], 32'h0);
        rd("ctrl final", OFF_CTRL, 32'hC0);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        chk("reset vector again", RESET_VEC, loaded);
        rd("ctrl reset again", OFF_CTRL, 32'h0);
        finish_test;
    end
endmodule
